// file: debug_unit_pkg.sv
// Operation
// RULE1: apart from trigger, flags set only while armed; disarmed events ignored
// RULE2: trigger flag bit 6 set on trigger while armed or while arming
// RULE3: flags cleared only by arming; contents kept after the session ends
// RULE4: each flag sets independently; a set flag never blocks another
// RULE5: external event flag bit 4 set by external event in a session
// RULE6: match flags bits 3..0, one per channel, set on channel match
// RULE7: state field bits 2..0 shows sequencer state, updated each transition
// RULE8: software disarm keeps last state in the state field
// RULE9: internal session end returns to disarmed and clears field to 000
// RULE10: arming enters State1 and forces field to 001
// RULE11: encodings 000 disarmed, 001..011 states 1..3, 100 final; rest reserved
// RULE12: comparator A control writable only while not armed
// RULE13: bit 6 inverts data match; ignored when instruction select set
// RULE14: bit 5 selects program counter compare, else data access address
// RULE15: bit 3 picks read (1) or write (0); ignored if unqualified or instruction
// RULE16: bit 2 enables direction qualification; ignored when instruction select set
// RULE17: qualified match needs bus direction equal to selected direction
// RULE18: bit 0 enables comparator A; when clear no matches
// RULE19: flag and status registers readable anytime; writes ignored
package debug_unit_pkg;

    // register indices; byte address is four times the index
    localparam logic [9:0] IDX_EVENT_FLAGS = 10'h10A;
    localparam logic [9:0] IDX_SEQ_STATUS = 10'h10B;
    localparam logic [9:0] IDX_CMP_A_CTL = 10'h110;
    localparam logic [9:0] IDX_SESSION_CTL = 10'h100;
    localparam logic [9:0] IDX_IRQ_STATUS = 10'h101;
    localparam logic [9:0] IDX_IRQ_CLEAR = 10'h102;
    localparam logic [9:0] IDX_IRQ_ENABLE = 10'h103;

    // event flag fields
    localparam int TRIGGER_FLAG_BIT = 6;
    localparam int EXTERNAL_EVENT_FLAG_BIT = 4;

    // comparator A control fields
    localparam int INVERTED_DATA_MATCH_BIT = 6;
    localparam int INSTRUCTION_SELECT_BIT = 5;
    localparam int DIRECTION_VALUE_BIT = 3;
    localparam int DIRECTION_QUALIFY_ENABLE_BIT = 2;
    localparam int COMPARATOR_ENABLE_BIT = 0;
    localparam logic [7:0] CMP_A_CTL_WMASK = 8'h6D;

    // session control and interrupt fields
    localparam int ARM_BIT = 0;
    localparam int IRQ_TRIGGER_BIT = 0;
    localparam int IRQ_SESSION_END_BIT = 1;
    localparam int IRQ_MATCH_A_BIT = 2;

    // reset values
    localparam logic [7:0] EVENT_FLAGS_RESET = 8'h00;
    localparam logic [7:0] CMP_A_CTL_RESET = 8'h00;
    localparam logic [2:0] IRQ_RESET = 3'h0;

    // sequencer state field encodings
    localparam logic [2:0] SEQ_DISARMED = 3'h0;
    localparam logic [2:0] SEQ_STATE1 = 3'h1;
    localparam logic [2:0] SEQ_STATE2 = 3'h2;
    localparam logic [2:0] SEQ_STATE3 = 3'h3;
    localparam logic [2:0] SEQ_FINAL = 3'h4;

    typedef enum logic [1:0] {BUS_IDLE, BUS_READ_WAIT, BUS_WRITE} bus_phase_e;

    // observed core bus, same clock domain
    typedef struct packed {
        logic data_valid;
        logic data_read;
        logic [23:0] data_addr;
        logic [31:0] data_value;
        logic pc_valid;
        logic [23:0] pc_addr;
    } cpu_obs_s;

    // comparator A reference values from the comparator register block
    typedef struct packed {
        logic [23:0] addr;
        logic [31:0] data;
        logic [31:0] mask;
    } cmp_ref_s;

endpackage

// file: debug_unit.sv
// Implementation choice: the AHB-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
module debug_unit
(
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire debug_unit_pkg::cpu_obs_s cpu_obs,
    input wire debug_unit_pkg::cmp_ref_s cmp_a_ref,
    input wire logic [2:0] channel_match,
    input wire logic trigger_event,
    input wire logic external_event_pin,
    input wire logic session_end_event,
    input wire logic seq_step_valid,
    input wire logic [2:0] seq_step_state,
    output logic comparator_a_match,
    output logic armed,
    output logic irq
);

    // register state
    logic [7:0] debug_event_flags;
    logic [2:0] sequencer_state_field;
    logic [7:0] comparator_a_control;
    logic [2:0] irq_status;
    logic [2:0] irq_enable;

    // bus state
    debug_unit_pkg::bus_phase_e bus_phase;
    logic [9:0] bus_index;

    // external event synchroniser
    logic ext_meta;
    logic ext_sync;

    // derived terms
    logic wr_fire;
    logic [7:0] wr_byte;
    logic arm_write;
    logic disarm_write;
    logic arming;
    logic session_end;
    logic next_match_a;
    logic [7:0] flag_set;
    logic [2:0] irq_event;

    function automatic logic is_reg(input logic [9:0] idx, input logic [9:0] which);
        is_reg = (idx == which);
    endfunction

    function automatic logic legal_state(input logic [2:0] code);
        legal_state = (code == debug_unit_pkg::SEQ_STATE1)
            || (code == debug_unit_pkg::SEQ_STATE2)
            || (code == debug_unit_pkg::SEQ_STATE3)
            || (code == debug_unit_pkg::SEQ_FINAL);
    endfunction

    // external event pin synchroniser
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            ext_meta <= 1'b0;
            ext_sync <= 1'b0;
        end
        else if (ce)
        begin
            ext_meta <= external_event_pin;
            ext_sync <= ext_meta;
        end
    end

    // bus phase tracking; reads insert one wait state
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            bus_phase <= debug_unit_pkg::BUS_IDLE;
            bus_index <= 10'h000;
            hreadyout <= 1'b1;
        end
        else if (ce)
        begin
            unique case (bus_phase)
                debug_unit_pkg::BUS_READ_WAIT:
                begin
                    bus_phase <= debug_unit_pkg::BUS_IDLE;
                    hreadyout <= 1'b1;
                end
                debug_unit_pkg::BUS_IDLE, debug_unit_pkg::BUS_WRITE:
                begin
                    if (hsel && htrans[1] && hready)
                    begin
                        bus_index <= haddr[11:2];
                        if (hwrite)
                        begin
                            bus_phase <= debug_unit_pkg::BUS_WRITE;
                        end
                        else
                        begin
                            bus_phase <= debug_unit_pkg::BUS_READ_WAIT;
                            hreadyout <= 1'b0;
                        end
                    end
                    else
                    begin
                        bus_phase <= debug_unit_pkg::BUS_IDLE;
                    end
                end
            endcase
        end
    end

    // response is always okay
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            hresp <= 1'b0;
        end
        else if (ce)
        begin
            hresp <= 1'b0;
        end
    end

    // read data; flag and status registers readable anytime [RULE19]
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            hrdata <= 32'h0000_0000;
        end
        else if (ce)
        begin
            if (bus_phase == debug_unit_pkg::BUS_READ_WAIT)
            begin
                hrdata <= 32'h0000_0000;
                if (is_reg(bus_index, debug_unit_pkg::IDX_EVENT_FLAGS))
                begin
                    hrdata[7:0] <= debug_event_flags; // [RULE19]
                end
                if (is_reg(bus_index, debug_unit_pkg::IDX_SEQ_STATUS))
                begin
                    hrdata[2:0] <= sequencer_state_field; // [RULE19]
                end
                if (is_reg(bus_index, debug_unit_pkg::IDX_CMP_A_CTL))
                begin
                    hrdata[7:0] <= comparator_a_control;
                end
                if (is_reg(bus_index, debug_unit_pkg::IDX_SESSION_CTL))
                begin
                    hrdata[debug_unit_pkg::ARM_BIT] <= armed;
                end
                if (is_reg(bus_index, debug_unit_pkg::IDX_IRQ_STATUS))
                begin
                    hrdata[2:0] <= irq_status;
                end
                if (is_reg(bus_index, debug_unit_pkg::IDX_IRQ_ENABLE))
                begin
                    hrdata[2:0] <= irq_enable;
                end
            end
        end
    end

    // write decode; writes to flag and status indices have no target [RULE19]
    assign wr_fire = ce && (bus_phase == debug_unit_pkg::BUS_WRITE);
    assign wr_byte = hwdata[7:0];
    assign arm_write = wr_fire && is_reg(bus_index, debug_unit_pkg::IDX_SESSION_CTL)
        && wr_byte[debug_unit_pkg::ARM_BIT];
    assign disarm_write = wr_fire && is_reg(bus_index, debug_unit_pkg::IDX_SESSION_CTL)
        && !wr_byte[debug_unit_pkg::ARM_BIT];
    assign arming = arm_write && !armed;
    assign session_end = armed && session_end_event && !disarm_write;

    // arm bit: set by software, cleared by software or internal end
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            armed <= 1'b0;
        end
        else if (ce)
        begin
            if (arming)
            begin
                armed <= 1'b1;
            end
            else if (disarm_write || session_end)
            begin
                armed <= 1'b0;
            end
        end
    end

    // comparator A control, locked while armed [RULE12]
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            comparator_a_control <= debug_unit_pkg::CMP_A_CTL_RESET;
        end
        else if (ce)
        begin
            if (wr_fire && !armed && is_reg(bus_index, debug_unit_pkg::IDX_CMP_A_CTL))
            begin
                comparator_a_control <= wr_byte & debug_unit_pkg::CMP_A_CTL_WMASK; // [RULE12]
            end
        end
    end

    // comparator A match logic
    always_comb
    begin
        logic data_hit;
        logic dir_ok;
        data_hit = 1'b0;
        dir_ok = 1'b1;
        next_match_a = 1'b0;
        if (comparator_a_control[debug_unit_pkg::INSTRUCTION_SELECT_BIT])
        begin
            // program counter compare; data and direction bits ignored [RULE14]
            next_match_a = cpu_obs.pc_valid && (cpu_obs.pc_addr == cmp_a_ref.addr);
        end
        else
        begin
            data_hit = ((cpu_obs.data_value ^ cmp_a_ref.data) & cmp_a_ref.mask) == 32'h0000_0000;
            if (comparator_a_control[debug_unit_pkg::INVERTED_DATA_MATCH_BIT])
            begin
                data_hit = !data_hit; // [RULE13]
            end
            if (comparator_a_control[debug_unit_pkg::DIRECTION_QUALIFY_ENABLE_BIT]) // [RULE16]
            begin
                dir_ok = (cpu_obs.data_read
                    == comparator_a_control[debug_unit_pkg::DIRECTION_VALUE_BIT]); // [RULE15] [RULE17]
            end
            next_match_a = cpu_obs.data_valid && (cpu_obs.data_addr == cmp_a_ref.addr)
                && data_hit && dir_ok; // [RULE14]
        end
        if (!comparator_a_control[debug_unit_pkg::COMPARATOR_ENABLE_BIT])
        begin
            next_match_a = 1'b0; // [RULE18]
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            comparator_a_match <= 1'b0;
        end
        else if (ce)
        begin
            comparator_a_match <= next_match_a; // [RULE18]
        end
    end

    // per-flag set terms, each independent of the others [RULE4]
    always_comb
    begin
        flag_set = 8'h00;
        flag_set[3:0] = {channel_match, next_match_a} & {4{armed}}; // [RULE6] [RULE1]
        flag_set[debug_unit_pkg::EXTERNAL_EVENT_FLAG_BIT] = armed && ext_sync; // [RULE5] [RULE1]
        flag_set[debug_unit_pkg::TRIGGER_FLAG_BIT] = trigger_event && (armed || arming); // [RULE2]
    end

    // event flags: cleared only by arming, otherwise sticky [RULE3]
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            debug_event_flags <= debug_unit_pkg::EVENT_FLAGS_RESET;
        end
        else if (ce)
        begin
            if (arming)
            begin
                debug_event_flags <= flag_set & (8'h01 << debug_unit_pkg::TRIGGER_FLAG_BIT); // [RULE3] [RULE2]
            end
            else
            begin
                debug_event_flags <= debug_event_flags | flag_set; // [RULE4] [RULE1]
            end
        end
    end

    // sequencer state field
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            sequencer_state_field <= debug_unit_pkg::SEQ_DISARMED;
        end
        else if (ce)
        begin
            if (arming)
            begin
                sequencer_state_field <= debug_unit_pkg::SEQ_STATE1; // [RULE10]
            end
            else if (disarm_write)
            begin
                sequencer_state_field <= sequencer_state_field; // [RULE8]
            end
            else if (session_end)
            begin
                sequencer_state_field <= debug_unit_pkg::SEQ_DISARMED; // [RULE9]
            end
            else if (armed && seq_step_valid && legal_state(seq_step_state)) // [RULE11]
            begin
                sequencer_state_field <= seq_step_state; // [RULE7]
            end
        end
    end

    // interrupt sources
    assign irq_event = {next_match_a && armed, session_end, flag_set[debug_unit_pkg::TRIGGER_FLAG_BIT]};

    // sticky status; set wins over a same-cycle clear
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            irq_status <= debug_unit_pkg::IRQ_RESET;
        end
        else if (ce)
        begin
            if (wr_fire && is_reg(bus_index, debug_unit_pkg::IDX_IRQ_CLEAR))
            begin
                irq_status <= (irq_status & ~wr_byte[2:0]) | irq_event;
            end
            else
            begin
                irq_status <= irq_status | irq_event;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            irq_enable <= debug_unit_pkg::IRQ_RESET;
        end
        else if (ce)
        begin
            if (wr_fire && is_reg(bus_index, debug_unit_pkg::IDX_IRQ_ENABLE))
            begin
                irq_enable <= wr_byte[2:0];
            end
        end
    end

    // registered interrupt level
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            irq <= 1'b0;
        end
        else if (ce)
        begin
            irq <= |(irq_status & irq_enable);
        end
    end

endmodule
`default_nettype wire

// file: debug_unit_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module debug_unit_asserts
(
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    input wire debug_unit_pkg::cpu_obs_s cpu_obs,
    input wire logic session_end_event,
    input wire logic comparator_a_match,
    input wire logic armed
);
    logic take;
    logic wr_ctl;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    assign take = ce && hsel && htrans[1] && hready;
    // session control write in its data phase
    always_ff @(posedge clk)
        wr_ctl <= !rst && take && hwrite && haddr[11:2] == debug_unit_pkg::IDX_SESSION_CTL;
    a_resp_okay: assert property (hresp == 1'h0)
        else $error("bus response not okay");
    a_read_one_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");
    a_write_no_wait: assert property (take && hwrite |=> hreadyout)
        else $error("write stalled");
    a_rdata_holds: assert property (!$rose(hreadyout) |-> $stable(hrdata))
        else $error("read data moved");
    a_arm_by_write: assert property ($rose(armed) |-> $past(wr_ctl))
        else $error("armed without write");
    a_disarm_cause: assert property ($fell(armed) |-> $past(wr_ctl) || $past(session_end_event))
        else $error("disarmed without cause");
    a_end_disarms: assert property (armed && session_end_event && !wr_ctl |=> !armed)
        else $error("session end ignored");
    a_match_cause: assert property ($rose(comparator_a_match)
        |-> $past(cpu_obs.data_valid) || $past(cpu_obs.pc_valid))
        else $error("match without bus cycle");
    c_session_end: cover property (armed && session_end_event);
    c_match: cover property ($rose(comparator_a_match));
    c_read: cover property (take && !hwrite);
    c_freeze: cover property (!ce && armed);
endmodule
`default_nettype wire

// file: cpu_bus_model.sv
`timescale 1ns/1ns
`default_nettype none
module cpu_bus_model
(
    input wire logic clk,
    output var debug_unit_pkg::cpu_obs_s obs
);
    initial obs = '0;
    // one observed cycle, then both valids clear and the other released lines show the inverse
    task automatic cycle(input logic pc, input logic rd, input logic [23:0] a,
        input logic [31:0] d);
        @(posedge clk);
        obs <= {~pc, rd, a, d, pc, a};
        @(posedge clk);
        obs <= {1'h0, ~rd, ~a, ~d, 1'h0, ~a};
    endtask
endmodule
`default_nettype wire

// file: test_debug_event_status_comparator_ctl.sv
`timescale 1ns/1ns
`default_nettype none
module test_debug_event_status_comparator_ctl;
    logic clk = 1'h0;
    logic rst = 1'h1;
    logic ce = 1'h1;
    logic hsel = 1'h0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    debug_unit_pkg::cpu_obs_s cpu_obs;
    debug_unit_pkg::cmp_ref_s cmp_a_ref = {24'h001234, 32'h000000A5, 32'hFFFFFFFF};
    logic [6:0] ev = 7'h0;
    logic [2:0] seq_step_state = 3'h0;
    logic comparator_a_match;
    logic armed;
    logic irq;
    int fail_count = 0;
    int total_checks = 0;
    logic [11:0] tbl [9] = '{12'h011, 12'h410, 12'h413, 12'h000, 12'h219,
        12'h0D5, 12'h054, 12'h2D9, 12'h61B};

    always #2 clk = ~clk;

    debug_unit i_debug_unit
    (
        .clk(clk), .rst(rst), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .cpu_obs(cpu_obs),
        .cmp_a_ref(cmp_a_ref), .channel_match(ev[2:0]), .trigger_event(ev[3]),
        .external_event_pin(ev[4]), .session_end_event(ev[5]), .seq_step_valid(ev[6]),
        .seq_step_state(seq_step_state), .comparator_a_match(comparator_a_match),
        .armed(armed), .irq(irq)
    );

    cpu_bus_model i_cpu_bus_model
    (
        .clk(clk),
        .obs(cpu_obs)
    );

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic ahb(input logic w, input logic [9:0] idx, input logic [31:0] d,
        output logic [31:0] q);
        @(posedge clk);
        {hsel, htrans, hwrite, haddr} <= {1'h1, 2'h2, w, 20'h0, idx, 2'h0};
        do @(posedge clk); while (hreadyout !== 1'h1);
        {hsel, htrans, hwdata} <= {1'h0, 2'h0, d};
        do @(posedge clk); while (hreadyout !== 1'h1);
        q = hrdata;
    endtask

    task automatic wr(input logic [9:0] idx, input logic [31:0] d);
        logic [31:0] q;
        ahb(1'h1, idx, d, q);
    endtask

    task automatic rchk(input logic [9:0] idx, input logic [31:0] exp);
        logic [31:0] q;
        ahb(1'h0, idx, 32'h0, q);
        chk(q, exp);
    endtask

    task automatic pulse(input logic [6:0] v, input logic [2:0] s);
        @(posedge clk);
        ev <= v;
        seq_step_state <= s;
        @(posedge clk);
        ev <= 7'h0;
    endtask

    task automatic t_reset_view();
        wr(debug_unit_pkg::IDX_EVENT_FLAGS, 32'hFF);
        wr(debug_unit_pkg::IDX_SEQ_STATUS, 32'hFF);
        rchk(debug_unit_pkg::IDX_EVENT_FLAGS, 32'h0);
        rchk(debug_unit_pkg::IDX_SEQ_STATUS, 32'h0);
        rchk(debug_unit_pkg::IDX_CMP_A_CTL, 32'h0);
        rchk(10'h200, 32'h0);
        wr(debug_unit_pkg::IDX_CMP_A_CTL, 32'hFF);
        rchk(debug_unit_pkg::IDX_CMP_A_CTL, 32'h6D);
    endtask

    task automatic t_disarmed();
        wr(debug_unit_pkg::IDX_CMP_A_CTL, 32'h0);
        pulse(7'h1F, 3'h0);
        i_cpu_bus_model.cycle(1'h0, 1'h0, 24'h001234, 32'hA5);
        repeat (4) @(posedge clk);
        rchk(debug_unit_pkg::IDX_EVENT_FLAGS, 32'h0);
    endtask

    task automatic t_armed_flags();
        wr(debug_unit_pkg::IDX_CMP_A_CTL, 32'h05);
        ev <= 7'h08;
        wr(debug_unit_pkg::IDX_SESSION_CTL, 32'h1);
        ev <= 7'h0;
        rchk(debug_unit_pkg::IDX_EVENT_FLAGS, 32'h40);
        rchk(debug_unit_pkg::IDX_SEQ_STATUS, 32'h1);
        wr(debug_unit_pkg::IDX_CMP_A_CTL, 32'h0);
        rchk(debug_unit_pkg::IDX_CMP_A_CTL, 32'h05);
        pulse(7'h15, 3'h0);
        i_cpu_bus_model.cycle(1'h0, 1'h1, 24'h001234, 32'hA5);
        #1;
        chk(comparator_a_match, 32'h0);
        i_cpu_bus_model.cycle(1'h0, 1'h0, 24'h001234, 32'hA5);
        #1;
        chk(comparator_a_match, 32'h1);
        rchk(debug_unit_pkg::IDX_EVENT_FLAGS, 32'h5B);
    endtask

    task automatic t_sequencer();
        for (int s = 2; s <= 4; s++)
        begin
            pulse(7'h40, 3'(s));
            rchk(debug_unit_pkg::IDX_SEQ_STATUS, 32'(s));
        end
        pulse(7'h40, 3'h5);
        rchk(debug_unit_pkg::IDX_SEQ_STATUS, 32'h4);
        wr(debug_unit_pkg::IDX_SESSION_CTL, 32'h0);
        rchk(debug_unit_pkg::IDX_SEQ_STATUS, 32'h4);
        pulse(7'h1F, 3'h0);
        repeat (4) @(posedge clk);
        rchk(debug_unit_pkg::IDX_EVENT_FLAGS, 32'h5B);
    endtask

    task automatic t_comparator();
        for (int i = 0; i < 9; i++)
        begin
            wr(debug_unit_pkg::IDX_CMP_A_CTL, {24'h0, tbl[i][11:4]});
            wr(debug_unit_pkg::IDX_SESSION_CTL, 32'h1);
            i_cpu_bus_model.cycle(tbl[i][3], tbl[i][2], 24'h001234,
                tbl[i][1] ? 32'h5A : 32'hA5);
            #1;
            chk(comparator_a_match, {31'h0, tbl[i][0]});
            wr(debug_unit_pkg::IDX_SESSION_CTL, 32'h0);
        end
    endtask

    task automatic t_freeze();
        wr(debug_unit_pkg::IDX_SESSION_CTL, 32'h1);
        ce <= 1'h0;
        pulse(7'h07, 3'h0);
        ce <= 1'h1;
        repeat (2) @(posedge clk);
        rchk(debug_unit_pkg::IDX_EVENT_FLAGS, 32'h0);
        wr(debug_unit_pkg::IDX_SESSION_CTL, 32'h0);
    endtask

    task automatic t_irq_end();
        wr(debug_unit_pkg::IDX_IRQ_CLEAR, 32'h7);
        wr(debug_unit_pkg::IDX_IRQ_ENABLE, 32'h0);
        wr(debug_unit_pkg::IDX_SESSION_CTL, 32'h1);
        rchk(debug_unit_pkg::IDX_EVENT_FLAGS, 32'h0);
        pulse(7'h20, 3'h0);
        rchk(debug_unit_pkg::IDX_IRQ_STATUS, 32'h2);
        rchk(debug_unit_pkg::IDX_SEQ_STATUS, 32'h0);
        chk(armed, 32'h0);
        chk(irq, 32'h0);
        wr(debug_unit_pkg::IDX_IRQ_ENABLE, 32'h2);
        repeat (2) @(posedge clk);
        chk(irq, 32'h1);
        wr(debug_unit_pkg::IDX_IRQ_CLEAR, 32'h2);
        repeat (2) @(posedge clk);
        chk(irq, 32'h0);
    endtask

    initial
    begin
        repeat (10) @(posedge clk);
        rst <= 1'h0;
        t_reset_view();
        t_disarmed();
        t_armed_flags();
        t_sequencer();
        t_comparator();
        t_freeze();
        t_irq_end();
        tally_and_finish();
    end

    initial
    begin
        #100000;
        fail_count++;
        tally_and_finish();
    end
endmodule

bind debug_unit debug_unit_asserts i_debug_unit_asserts
(
    .clk, .rst, .ce, .hsel, .haddr, .htrans, .hwrite, .hready, .hreadyout, .hresp,
    .hrdata, .cpu_obs, .session_end_event, .comparator_a_match, .armed
);
`default_nettype wire
